/* shared/rta_pkg.sv */
// constants shared by the rtc serial access block
package rta_pkg;
  // --------------------------------------------------------------
  // serial addressing
  // --------------------------------------------------------------
  localparam logic [6:0] SLAVE_ADDR   = 7'h32;  // 0110010
  localparam logic [3:0] FMT_WRITE    = 4'h0;   // pointer write / repeated start read
  localparam logic [3:0] FMT_READ_NOW = 4'h4;   // read right after the pointer byte
  localparam logic [3:0] PTR_TOP      = 4'hF;   // pointer value after stop
  localparam logic [7:0] IDLE_BYTE    = 8'hFF;  // read data after a timeout
  localparam logic [3:0] BIT_LAST     = 4'h8;   // bit count of a full byte
  // --------------------------------------------------------------
  // time counter locations and limits
  // --------------------------------------------------------------
  localparam logic [3:0] LOC_SEC      = 4'h0;
  localparam logic [3:0] LOC_MIN      = 4'h1;
  localparam logic [3:0] LOC_HOUR     = 4'h2;
  localparam logic [7:0] SEC_MAX      = 8'h3B;  // 59
  localparam logic [7:0] HOUR_MAX     = 8'h17;  // 23
  // --------------------------------------------------------------
  // timing
  // --------------------------------------------------------------
  localparam int          CLK_MHZ       = 40;
  localparam int          CARRY_US      = 61;   // deferred carry deadline
  localparam int          CARRY_CYC     = CARRY_US * CLK_MHZ;  // longest wait in system clock cycles
  localparam logic [14:0] SEC_TICKS_M1  = 15'h7FFF;  // 32768 timebase edges per second
  localparam logic [14:0] TMO_TICKS_DEF = 15'h4000;  // 0.5 s of timebase edges
  // --------------------------------------------------------------
  // bus engine states
  // --------------------------------------------------------------
  typedef enum logic [2:0] {
    RTA_IDLE  = 3'b000,  // not addressed
    RTA_RX    = 3'b001,  // shifting in a byte
    RTA_ACK   = 3'b010,  // answering a received byte
    RTA_TX    = 3'b011,  // shifting out a byte
    RTA_TXACK = 3'b100   // master answers a sent byte
  } rta_state_t;
  typedef enum logic [1:0] {
    RTA_K_ADDR = 2'b00,
    RTA_K_PTR  = 2'b01,
    RTA_K_DATA = 2'b10
  } rta_kind_t;
endpackage

/* rtl/rta_access.sv */
// rtc serial slave with access hold, deferred carry and access timeout
`timescale 1ns/1ps
`default_nettype none
// Contract
// - answer slave address 0110010, msb first
// - second write byte: pointer high, format low
// - pointer increments per byte, wraps F to 0
// - every stop loads pointer with F
// - format 4: read starts right after ack
// - read without pointer write starts at F
// - freeze counters from start, hold carries
// - apply held carry within 61 us after stop
// - 0.5-1.0 s after start, act as stop
// - repeated start does not restart timeout
// - after timeout: no write ack, reads FFh
// - free-running 32.768 kHz on clock output pin
module rta_access #(
  parameter logic [14:0] TMO_TICKS = rta_pkg::TMO_TICKS_DEF  // timebase edges to timeout
) (
  input  wire logic ref_clk,                 // 40 MHz system clock
  input  wire logic rst_n,                   // async reset, active low
  input  wire logic scl_in,                  // serial clock level
  input  wire logic sda_in,                  // serial data level
  input  wire logic osc_in,                  // 32.768 kHz timebase level
  output logic      sda_out,                 // data drive value, always low
  output logic      sda_oe,                  // high while pulling data low
  output logic      fixed_clock_output_pin,  // 32.768 kHz copy
  output logic      access_hold              // counters frozen
);
  import rta_pkg::*;

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic        scl_d_r, sda_d_r, osc_d_r;   // previous samples
  rta_state_t  st_r;                        // bus engine state
  rta_kind_t   kind_r;                      // meaning of byte being received
  logic [3:0]  bit_r;                       // bits done in current byte
  logic [7:0]  sh_r;                        // shift register
  logic [3:0]  ptr_r;                       // internal address pointer
  logic        ack_r;                       // drive ack in RTA_ACK
  logic        rd_r;                        // direction after current ack
  logic        acc_r;                       // access in progress
  logic        tmo_r;                       // access ended by timeout
  logic [14:0] tmo_cnt_r;                   // timeout timebase counter
  logic [14:0] div_r;                       // one second divider
  logic        pend_r;                      // carry held during freeze
  logic [7:0]  mem_r [16];                  // internal locations

  // ------------------------------------------------------------
  // bus conditions
  // ------------------------------------------------------------
  logic start_c, stop_c, scl_rise, scl_fall, osc_rise, frozen, tick;
  assign start_c  = scl_in & scl_d_r & sda_d_r & ~sda_in;
  assign stop_c   = scl_in & scl_d_r & ~sda_d_r & sda_in;
  assign scl_rise = scl_in & ~scl_d_r;
  assign scl_fall = ~scl_in & scl_d_r;
  assign osc_rise = osc_in & ~osc_d_r;
  assign frozen   = acc_r & ~tmo_r;          // timeout releases the hold
  assign tick     = osc_rise & (div_r == SEC_TICKS_M1);
  // timeout fires on the timebase, independent of the serial clock
  logic tmo_fire;
  assign tmo_fire = frozen & osc_rise & (tmo_cnt_r == TMO_TICKS - 15'h0001);

  // ------------------------------------------------------------
  // input history
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
      osc_d_r <= 1'b0;
    end else begin
      scl_d_r <= scl_in;
      sda_d_r <= sda_in;
      osc_d_r <= osc_in;
    end
  end

  // ------------------------------------------------------------
  // clock output and second divider
  // ------------------------------------------------------------
  // copy of the timebase; no gating so it runs free
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) fixed_clock_output_pin <= 1'b0;
    else        fixed_clock_output_pin <= osc_in;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n)        div_r <= 15'h0000;
    else if (osc_rise) div_r <= div_r + 15'h0001;
  end

  // ------------------------------------------------------------
  // access window and timeout
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_r     <= 1'b0;
      tmo_r     <= 1'b0;
      tmo_cnt_r <= 15'h0000;
    end else if (stop_c) begin
      acc_r <= 1'b0;
      tmo_r <= 1'b0;
    end else if (start_c && !acc_r) begin
      acc_r     <= 1'b1;
      tmo_cnt_r <= 15'h0000;
    end else if (tmo_fire) begin
      tmo_r <= 1'b1;
    end else if (frozen && osc_rise) begin
      // repeated starts fall through here and keep counting
      tmo_cnt_r <= tmo_cnt_r + 15'h0001;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) access_hold <= 1'b0;
    else        access_hold <= frozen & ~tmo_fire & ~stop_c;
  end

  // ------------------------------------------------------------
  // held carry
  // ------------------------------------------------------------
  // the carry lands on the first cycle after release, far inside
  // the CARRY_CYC budget, so no counter is needed for it
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n)      pend_r <= 1'b0;
    else if (frozen) pend_r <= pend_r | tick;
    else             pend_r <= tick & pend_r;
  end

  // ------------------------------------------------------------
  // bus engine
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r   <= RTA_IDLE;
      kind_r <= RTA_K_ADDR;
      bit_r  <= 4'h0;
      sh_r   <= 8'h00;
      ptr_r  <= PTR_TOP;
      ack_r  <= 1'b0;
      rd_r   <= 1'b0;
    end else if (stop_c || tmo_fire) begin
      if (stop_c) st_r <= RTA_IDLE;
      ptr_r <= PTR_TOP;
    end else if (start_c) begin
      st_r   <= RTA_RX;                        // start or repeated start
      kind_r <= RTA_K_ADDR;
      bit_r  <= 4'h0;
    end else begin
      unique case (st_r)
        RTA_IDLE: begin
          bit_r <= 4'h0;                       // ignore until next start
        end
        RTA_RX: begin
          if (scl_rise) begin
            sh_r  <= {sh_r[6:0], sda_in};
            bit_r <= bit_r + 4'h1;
          end else if (scl_fall && bit_r == BIT_LAST) begin
            st_r <= RTA_ACK;
            unique case (kind_r)
              RTA_K_ADDR: begin
                ack_r <= (sh_r[7:1] == SLAVE_ADDR) & ~tmo_r;
                rd_r  <= sh_r[0];
                if (sh_r[7:1] != SLAVE_ADDR) st_r <= RTA_IDLE;
              end
              RTA_K_PTR: begin
                ack_r <= ~tmo_r;
                if (!tmo_r) ptr_r <= sh_r[7:4];
                rd_r  <= (sh_r[3:0] == FMT_READ_NOW);
              end
              default: begin
                ack_r <= ~tmo_r;
                if (!tmo_r) ptr_r <= ptr_r + 4'h1;
                rd_r  <= 1'b0;
              end
            endcase
          end
        end
        RTA_ACK: begin
          if (scl_fall) begin
            bit_r <= 4'h0;
            ack_r <= 1'b0;
            if (rd_r) begin
              st_r <= RTA_TX;
              sh_r <= tmo_r ? IDLE_BYTE : mem_r[ptr_r];
            end else begin
              st_r   <= RTA_RX;
              kind_r <= (kind_r == RTA_K_ADDR) ? RTA_K_PTR : RTA_K_DATA;
            end
          end
        end
        RTA_TX: begin
          if (scl_fall) begin
            sh_r  <= {sh_r[6:0], 1'b1};
            bit_r <= bit_r + 4'h1;
            if (bit_r == BIT_LAST - 4'h1) begin
              st_r <= RTA_TXACK;
              if (!tmo_r) ptr_r <= ptr_r + 4'h1;
            end
          end
        end
        RTA_TXACK: begin
          if (scl_rise) begin
            rd_r <= ~sda_in;                   // master ack keeps reading
          end else if (scl_fall) begin
            bit_r <= 4'h0;
            st_r  <= rd_r ? RTA_TX : RTA_IDLE;
            sh_r  <= tmo_r ? IDLE_BYTE : mem_r[ptr_r];
          end
        end
        default: st_r <= RTA_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // data pin, open drain
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sda_oe  <= 1'b0;
      sda_out <= 1'b0;
    end else begin
      sda_out <= 1'b0;
      sda_oe  <= (st_r == RTA_ACK && ack_r) || (st_r == RTA_TX && !sh_r[7]);
    end
  end

  // ------------------------------------------------------------
  // locations and time counters
  // ------------------------------------------------------------
  // host writes only happen while frozen, counting only while not,
  // so the two never collide
  logic step;
  assign step = ~frozen & (tick | pend_r);
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 16; i++) mem_r[i] <= 8'h00;
    end else if (st_r == RTA_RX && kind_r == RTA_K_DATA && scl_fall
                 && bit_r == BIT_LAST && frozen && !stop_c && !start_c) begin
      mem_r[ptr_r] <= sh_r;
    end else if (step) begin
      if (mem_r[LOC_SEC] != SEC_MAX) begin
        mem_r[LOC_SEC] <= mem_r[LOC_SEC] + 8'h01;
      end else begin
        mem_r[LOC_SEC] <= 8'h00;
        if (mem_r[LOC_MIN] != SEC_MAX) begin
          mem_r[LOC_MIN] <= mem_r[LOC_MIN] + 8'h01;
        end else begin
          mem_r[LOC_MIN]  <= 8'h00;
          mem_r[LOC_HOUR] <= (mem_r[LOC_HOUR] == HOUR_MAX) ? 8'h00 : mem_r[LOC_HOUR] + 8'h01;
        end
      end
    end
  end
endmodule
`default_nettype wire

/* dv/rta_master.sv */
// two-wire bus master model for the serial access block
`timescale 1ns/1ps
`default_nettype none
module rta_master (
  input  wire logic clk,     // system clock
  input  wire logic sda_oe,  // device pulls data low
  output logic      scl,     // serial clock, idles high
  output wire logic sda      // resolved data wire
);
  logic sda_m;  // master drive, 1 releases the wire
  // pull-up wins unless either side pulls low
  assign sda = sda_m & ~sda_oe;
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  // move just after a clock edge
  task automatic w(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // start or repeated start: data falls while clock high
  task automatic start();
    sda_m = 1'b1;
    w(4);
    scl = 1'b1;
    w(8);
    sda_m = 1'b0;
    w(8);
    scl = 1'b0;
    w(4);
  endtask
  // stop: data rises while clock high, then a quiet gap
  task automatic stop();
    sda_m = 1'b0;
    w(4);
    scl = 1'b1;
    w(8);
    sda_m = 1'b1;
    w(2480);
  endtask
  // one clock pulse; data set while low, sampled mid-high
  task automatic clk_bit(input logic b, output logic r);
    sda_m = b;
    w(4);
    scl = 1'b1;
    w(4);
    r = sda;
    w(4);
    scl = 1'b0;
    w(4);
  endtask
  // eight bits msb first, then the answer bit
  task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(d[i], r);
      q[i] = r;
    end
    clk_bit(ack_in, ack);
  endtask
endmodule
`default_nettype wire

/* dv/rta_access_chk.sv */
// assertions on the serial access block ports
`timescale 1ns/1ps
`default_nettype none
module rta_access_chk #(
  parameter logic [14:0] TMO_TICKS = rta_pkg::TMO_TICKS_DEF  // timeout in timebase edges
) (
  input wire logic ref_clk,                 // system clock
  input wire logic rst_n,                   // async reset, active low
  input wire logic scl_in,                  // serial clock
  input wire logic sda_in,                  // data wire
  input wire logic osc_in,                  // timebase
  input wire logic sda_out,                 // drive value
  input wire logic sda_oe,                  // pull enable
  input wire logic fixed_clock_output_pin,  // clock copy
  input wire logic access_hold              // freeze flag
);
  logic [15:0] tick_r;  // timebase edges since hold rose
  logic        osc_d_r; // timebase last cycle
  logic        scl_d_r; // clock last cycle
  logic        sda_d_r; // data last cycle
  logic        stop_r;  // bus free: stop seen since last start
  // helper history; the counter spans up to thousands of cycles
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      // idle bus levels, so no false start or stop right after reset
      {osc_d_r, scl_d_r, sda_d_r, stop_r} <= 4'h7;
      tick_r <= 16'h0000;
    end else begin
      {osc_d_r, scl_d_r, sda_d_r} <= {osc_in, scl_in, sda_in};
      if (scl_in && scl_d_r && sda_in != sda_d_r) begin
        stop_r <= sda_in;
      end
      if (!access_hold) begin
        tick_r <= 16'h0000;
      end else if (osc_in && !osc_d_r) begin
        tick_r <= tick_r + 16'h0001;
      end
    end
  end
  sequence start_s;
    scl_in && scl_d_r && sda_d_r && !sda_in;
  endsequence
  sequence stop_s;
    scl_in && scl_d_r && !sda_d_r && sda_in;
  endsequence
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // only a first start opens the hold; a repeated start after a timeout leaves it released
  hold_on_start_a: assert property (start_s ##0 stop_r |-> ##[1:4] access_hold) else $error("no hold after start");
  hold_off_stop_a: assert property (stop_s |-> ##[1:4] !access_hold) else $error("hold after stop");
  idle_quiet_a: assert property (!access_hold [*3] |-> !sda_oe) else $error("drive while idle");
  oe_steady_a: assert property (scl_in && scl_d_r |-> $stable(sda_oe)) else $error("data moved in clock high");
  drive_low_a: assert property (sda_oe |-> !sda_out) else $error("drive not low");
  clk_copy_a: assert property ($past(rst_n) |-> fixed_clock_output_pin == $past(osc_in)) else $error("clock pin");
  tmo_max_a: assert property (access_hold |-> tick_r <= {1'b0, TMO_TICKS}) else $error("timeout late");
  tmo_floor_a: assert property ($fell(access_hold) && !stop_r |-> tick_r + 16'h0001 >= {1'b0, TMO_TICKS})
    else $error("timeout early");
endmodule
bind rta_access rta_access_chk #(.TMO_TICKS(TMO_TICKS)) rta_access_chk_inst (.ref_clk(ref_clk), .rst_n(rst_n),
  .scl_in(scl_in), .sda_in(sda_in), .osc_in(osc_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .fixed_clock_output_pin(fixed_clock_output_pin), .access_hold(access_hold));
`default_nettype wire

/* dv/rta_access_read_hold_test.sv */
// testbench for the serial access block
`timescale 1ns/1ps
`default_nettype none
module rtc_i2c_read_access_hold_test;
  import rta_pkg::*;
  logic       ref_clk, rst_n, osc_in, scl, sda, sda_out, sda_oe, clk_pin, hold;  // block pins
  logic [7:0] q, a;                  // last read byte, last answer bit
  int         err_count, checked;    // tallies
  // short timeout keeps the run small
  rta_access #(.TMO_TICKS(15'h0008)) rta_access_inst (.ref_clk(ref_clk), .rst_n(rst_n), .scl_in(scl),
    .sda_in(sda), .osc_in(osc_in), .sda_out(sda_out), .sda_oe(sda_oe), .fixed_clock_output_pin(clk_pin),
    .access_hold(hold));
  rta_master rta_master_inst (.clk(ref_clk), .sda_oe(sda_oe), .scl(scl), .sda(sda));
  always #12.5 ref_clk = ~ref_clk;
  // timebase near 32.768 kHz, 1220 cycles a period
  always begin
    repeat (610) @(posedge ref_clk);
    #1 osc_in = ~osc_in;
  end
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    checked++;
    if (s !== e) begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic wb(input logic [7:0] d);
    logic [7:0] t;
    logic       r;
    rta_master_inst.xfer(d, 1'b1, t, r);
    a = {7'h00, r};
  endtask
  task automatic rb(input logic nack);
    logic r;
    rta_master_inst.xfer(8'hFF, nack, q, r);
  endtask
  // read one byte straight after the pointer byte
  task automatic rd_now(input logic [3:0] p);
    rta_master_inst.start();
    wb({SLAVE_ADDR, 1'b0});
    wb({p, FMT_READ_NOW});
    rb(1'b1);
    rta_master_inst.stop();
  endtask
  task automatic t_fmt4();
    rta_master_inst.start();
    chk({7'h00, hold}, 8'h01);
    wb({SLAVE_ADDR, 1'b0});
    chk(a, 8'h00);
    wb({4'h3, FMT_WRITE});
    chk(a, 8'h00);
    wb(8'hA5);
    chk(a, 8'h00);
    rta_master_inst.stop();
    rd_now(4'h3);
    chk(q, 8'hA5);
    $display("test fmt4 done");
  endtask
  task automatic t_ptr();
    rta_master_inst.start();
    wb({SLAVE_ADDR, 1'b0});
    wb({PTR_TOP, FMT_WRITE});
    wb(8'h5A);
    wb(8'h21);
    rta_master_inst.stop();
    rta_master_inst.start();
    wb({SLAVE_ADDR, 1'b1});
    rb(1'b0);
    chk(q, 8'h5A);
    rb(1'b1);
    chk(q, 8'h21);
    rta_master_inst.stop();
    rta_master_inst.start();
    wb({SLAVE_ADDR, 1'b0});
    wb({4'h3, FMT_WRITE});
    rta_master_inst.start();
    wb({SLAVE_ADDR, 1'b1});
    rb(1'b1);
    chk(q, 8'hA5);
    rta_master_inst.stop();
    rta_master_inst.start();
    wb({SLAVE_ADDR, 1'b1});
    rb(1'b1);
    chk(q, 8'h5A);
    chk({7'h00, hold}, 8'h01);
    rta_master_inst.stop();
    $display("test pointer done");
  endtask
  task automatic t_addr();
    rta_master_inst.start();
    wb({7'h26, 1'b0});  // address bits sent reversed
    chk(a, 8'h01);
    rta_master_inst.stop();
    $display("test address done");
  endtask
  task automatic t_tmo();
    rta_master_inst.start();
    wb({SLAVE_ADDR, 1'b0});
    wb({4'h3, FMT_WRITE});
    rta_master_inst.w(6104);
    rta_master_inst.start();
    wb({SLAVE_ADDR, 1'b0});
    chk(a, 8'h00);
    rta_master_inst.w(6104);
    chk({7'h00, hold}, 8'h00);
    // pointer byte refused, so a broken pointer load would land 0x77 at location 3
    wb({4'h3, FMT_WRITE});
    chk(a, 8'h01);
    wb(8'h77);
    chk(a, 8'h01);
    // a real read here would show location F (0x5A), not all ones
    rta_master_inst.start();
    wb({SLAVE_ADDR, 1'b1});
    rb(1'b1);
    chk(q, IDLE_BYTE);
    rta_master_inst.stop();
    rd_now(4'h3);
    chk(q, 8'hA5);
    $display("test timeout done");
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    ref_clk = 1'b0;
    osc_in = 1'b0;
    rst_n = 1'b0;
    err_count = 0;
    checked = 0;
    repeat (6) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    rta_master_inst.w(4);
    t_fmt4();
    t_ptr();
    t_addr();
    t_tmo();
    end_of_test();
  end
  // cut a hang short; the tests need about 40k clocks
  initial begin
    #2000000;
    err_count++;
    end_of_test();
  end
endmodule
`default_nettype wire
